// ==== inc/ita_pkg.sv ====
package ita_pkg;
   // Register byte addresses
   localparam logic [31:0] ITA_ADDR_CTRL     = 32'h5000_1300;
   localparam logic [31:0] ITA_ADDR_TARGET   = 32'h5000_1304;
   localparam logic [31:0] ITA_ADDR_INT_STAT = 32'h5000_132C;
   localparam logic [31:0] ITA_ADDR_INT_MASK = 32'h5000_1330;
   localparam logic [31:0] ITA_ADDR_CLEAR    = 32'h5000_1340;
   localparam logic [31:0] ITA_ADDR_CAUSE    = 32'h5000_1380;

   localparam int unsigned ITA_CAUSE_W = 16;
   localparam int unsigned ITA_CTRL_W  = 16;
   localparam int unsigned ITA_TAR_W   = 16;

   // Reset values
   localparam logic [15:0] ITA_CAUSE_RST = 16'h0000;
   localparam logic [15:0] ITA_CTRL_RST  = 16'h0000;
   localparam logic [15:0] ITA_TAR_RST   = 16'h0000;

   // Control and target field positions
   localparam int unsigned ITA_CTRL_RESTART_BIT = 5;
   localparam int unsigned ITA_TAR_START_BYTE_SELECT_ENABLE_BIT  = 11;
   localparam int unsigned ITA_TAR_GC_BIT       = 10;

   // Abort cause bit positions
   localparam int unsigned ITA_B_SBYTE_NORST  = 9;
   localparam int unsigned ITA_B_HS_NORST     = 8;
   localparam int unsigned ITA_B_SBYTE_ACKED  = 7;
   localparam int unsigned ITA_B_HS_ACKED     = 6;
   localparam int unsigned ITA_B_GCALL_READ   = 5;
   localparam int unsigned ITA_B_GCALL_NOACK  = 4;
   localparam int unsigned ITA_B_DATA_NOACK   = 3;
   localparam int unsigned ITA_B_TEN2_NOACK   = 2;
   localparam int unsigned ITA_B_TEN1_NOACK   = 1;
   localparam int unsigned ITA_B_SEVEN_NOACK  = 0;

   // Interrupt status bit for the abort event
   localparam int unsigned ITA_INT_ABORT_BIT = 0;

   // SCL rising edges per byte, acknowledge on the last
   localparam logic [3:0] ITA_ACK_EDGE = 4'h9;

   typedef enum logic [2:0] {
      ITA_KIND_NONE,
      ITA_KIND_ADDR7,
      ITA_KIND_ADDR10_1,
      ITA_KIND_ADDR10_2,
      ITA_KIND_DATA,
      ITA_KIND_GCALL,
      ITA_KIND_SBYTE,
      ITA_KIND_HSCODE
   } ita_kind_t;
endpackage : ita_pkg

// ==== rtl/ita_sync.sv ====
`timescale 1ns/100ps
module ita_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic d,
   output logic      q,
   output logic      rise
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign q    = s2_r;
   assign rise = s2_r & ~s3_r;
endmodule : ita_sync

// ==== rtl/ita_ack_mon.sv ====
`timescale 1ns/100ps
module ita_ack_mon
   import ita_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic byte_start,
   input  wire logic scl_rise,
   input  wire logic sda_s,
   output logic      ack_valid,
   output logic      ack_seen
);
   logic [3:0] edge_cnt_r;
   logic       armed_r;

   // Counts SCL rises of one byte; samples SDA on the ninth
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_cnt_r <= 4'h0;
         armed_r    <= 1'b0;
         ack_valid  <= 1'b0;
         ack_seen   <= 1'b0;
      end else begin
         ack_valid <= 1'b0;
         if (byte_start) begin
            edge_cnt_r <= 4'h0;
            armed_r    <= 1'b1;
         end else if (armed_r && scl_rise) begin
            edge_cnt_r <= edge_cnt_r + 4'h1;
            if (edge_cnt_r + 4'h1 == ITA_ACK_EDGE) begin
               armed_r   <= 1'b0;
               ack_valid <= 1'b1;
               ack_seen  <= ~sda_s;
            end
         end
      end
   end
endmodule : ita_ack_mon

// ==== rtl/ita_abort_cause.sv ====
// Contract
// - Restart disabled and START byte requested sets cause bit 9.
// - Clearing bit 9 with its condition still present drops it one cycle.
// - Condition removed when restart enabled or either target select clear.
// - Restart disabled and high-speed transfer requested sets bit 8.
// - START byte acknowledged by a bus device sets bit 7.
// - High-speed master code acknowledged sets bit 6.
// - General call followed by a queued read command sets bit 5.
// - General call not acknowledged by any slave sets bit 4.
// - Master mode, address acked, data byte not acked sets bit 3.
// - Ten-bit addressing, second address byte not acked sets bit 2.
// - Ten-bit addressing, first address byte not acked sets bit 1.
// - Seven-bit address not acknowledged sets bit 0.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
module ita_abort_cause
   import ita_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   input  wire logic        mst_mode,
   input  wire logic        byte_start,
   input  ita_kind_t        byte_kind,
   input  wire logic        next_cmd_read,
   input  wire logic        req_start_byte,
   input  wire logic        req_high_speed,
   output logic             master_abort,
   output logic             irq
);
   logic [ITA_CTRL_W-1:0]  ctrl_r;
   logic [ITA_TAR_W-1:0]   tar_r;
   logic [ITA_CAUSE_W-1:0] cause_r;
   logic [ITA_CAUSE_W-1:0] cause_nxt;
   logic [ITA_CAUSE_W-1:0] set_vec;
   logic [ITA_CAUSE_W-1:0] clr_vec;
   logic                   int_stat_r;
   logic                   int_mask_r;
   logic                   sbyte_cond_r;
   logic                   restart_en;
   logic                   sbyte_fixed;
   ita_kind_t              kind_r;
   logic                   scl_rise;
   logic                   sda_s;
   logic                   ack_valid;
   logic                   ack_seen;
   logic                   wr_en;
   logic                   setup;
   logic                   hit;

   // Pin synchronisers and link edge detection
   ita_sync u_scl_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (scl_in),
      .q       (),
      .rise    (scl_rise)
   );

   ita_sync u_sda_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (sda_in),
      .q       (sda_s),
      .rise    ()
   );

   ita_ack_mon u_ack_mon (
      .pclk       (pclk),
      .presetn    (presetn),
      .byte_start (byte_start),
      .scl_rise   (scl_rise),
      .sda_s      (sda_s),
      .ack_valid  (ack_valid),
      .ack_seen   (ack_seen)
   );

   // APB access decode
   assign setup  = psel & ~penable;
   assign wr_en  = psel & penable & pwrite;
   assign pready = 1'b1;

   always_comb begin
      if (paddr == ITA_ADDR_CTRL) begin
         hit = 1'b1;
      end else if (paddr == ITA_ADDR_TARGET) begin
         hit = 1'b1;
      end else if (paddr == ITA_ADDR_INT_STAT) begin
         hit = 1'b1;
      end else if (paddr == ITA_ADDR_INT_MASK) begin
         hit = 1'b1;
      end else if (paddr == ITA_ADDR_CLEAR) begin
         hit = 1'b1;
      end else if (paddr == ITA_ADDR_CAUSE) begin
         hit = 1'b1;
      end else begin
         hit = 1'b0;
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= ~hit;
         if (pwrite) begin
            prdata <= 32'h0000_0000;
         end else if (paddr == ITA_ADDR_CTRL) begin
            prdata <= {16'h0000, ctrl_r};
         end else if (paddr == ITA_ADDR_TARGET) begin
            prdata <= {16'h0000, tar_r};
         end else if (paddr == ITA_ADDR_INT_STAT) begin
            prdata <= {31'h0000_0000, int_stat_r};
         end else if (paddr == ITA_ADDR_INT_MASK) begin
            prdata <= {31'h0000_0000, int_mask_r};
         end else if (paddr == ITA_ADDR_CAUSE) begin
            prdata <= {16'h0000, cause_r};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // Software control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r     <= ITA_CTRL_RST;
         tar_r      <= ITA_TAR_RST;
         int_mask_r <= 1'b0;
      end else if (wr_en) begin
         if (paddr == ITA_ADDR_CTRL) begin
            ctrl_r <= pwdata[ITA_CTRL_W-1:0];
         end else if (paddr == ITA_ADDR_TARGET) begin
            tar_r <= pwdata[ITA_TAR_W-1:0];
         end else if (paddr == ITA_ADDR_INT_MASK) begin
            int_mask_r <= pwdata[ITA_INT_ABORT_BIT];
         end
      end
   end

   // Write-one-to-clear strobe for cause bits
   assign clr_vec = (wr_en && paddr == ITA_ADDR_CLEAR)
                    ? pwdata[ITA_CAUSE_W-1:0] : '0;

   assign restart_en  = ctrl_r[ITA_CTRL_RESTART_BIT];
   assign sbyte_fixed = restart_en
                        | ~tar_r[ITA_TAR_START_BYTE_SELECT_ENABLE_BIT]
                        | ~tar_r[ITA_TAR_GC_BIT];

   // START byte without restart: level held until fixed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sbyte_cond_r <= 1'b0;
      end else if (sbyte_fixed) begin
         sbyte_cond_r <= 1'b0;
      end else if (req_start_byte && !restart_en) begin
         sbyte_cond_r <= 1'b1;
      end
   end

   // Kind of the byte in flight
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         kind_r <= ITA_KIND_NONE;
      end else if (byte_start) begin
         kind_r <= byte_kind;
      end
   end

   // Cause events
   always_comb begin
      set_vec = '0;
      set_vec[ITA_B_SBYTE_NORST] = sbyte_cond_r
                                   & ~clr_vec[ITA_B_SBYTE_NORST];
      set_vec[ITA_B_HS_NORST]    = req_high_speed & ~restart_en;
      if (ack_valid) begin
         set_vec[ITA_B_SBYTE_ACKED] = (kind_r == ITA_KIND_SBYTE)
                                      & ack_seen;
         set_vec[ITA_B_HS_ACKED]    = (kind_r == ITA_KIND_HSCODE)
                                      & ack_seen;
         set_vec[ITA_B_GCALL_READ]  = (kind_r == ITA_KIND_GCALL)
                                      & ack_seen & next_cmd_read;
         set_vec[ITA_B_GCALL_NOACK] = (kind_r == ITA_KIND_GCALL)
                                      & ~ack_seen;
         set_vec[ITA_B_DATA_NOACK]  = (kind_r == ITA_KIND_DATA)
                                      & ~ack_seen & mst_mode;
         set_vec[ITA_B_TEN2_NOACK]  = (kind_r == ITA_KIND_ADDR10_2)
                                      & ~ack_seen;
         set_vec[ITA_B_TEN1_NOACK]  = (kind_r == ITA_KIND_ADDR10_1)
                                      & ~ack_seen;
         set_vec[ITA_B_SEVEN_NOACK] = (kind_r == ITA_KIND_ADDR7)
                                      & ~ack_seen;
      end
   end

   // Set wins over clear, except bit 9 which drops for one cycle
   assign cause_nxt = (cause_r & ~clr_vec) | set_vec;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_r <= ITA_CAUSE_RST;
      end else begin
         cause_r <= cause_nxt;
      end
   end

   // Abort pulse on any newly set cause bit; stops the master
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_abort <= 1'b0;
      end else begin
         master_abort <= |(set_vec & ~cause_r);
      end
   end

   // Sticky interrupt status, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_r <= 1'b0;
      end else if (master_abort) begin
         int_stat_r <= 1'b1;
      end else if (wr_en && paddr == ITA_ADDR_INT_STAT
                   && pwdata[ITA_INT_ABORT_BIT]) begin
         int_stat_r <= 1'b0;
      end
   end

   assign irq = int_stat_r & int_mask_r;

   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_sbyte_set;
      req_start_byte && !restart_en && !sbyte_fixed
      ##1 !sbyte_fixed && !clr_vec[ITA_B_SBYTE_NORST]
      |=> cause_r[ITA_B_SBYTE_NORST];
   endproperty
   a_sbyte_set: assert property (p_sbyte_set)
      else $error("start byte abort not set");

   property p_sbyte_reassert;
      clr_vec[ITA_B_SBYTE_NORST] && sbyte_cond_r
      ##1 sbyte_cond_r && !clr_vec[ITA_B_SBYTE_NORST]
      |-> !cause_r[ITA_B_SBYTE_NORST] ##1 cause_r[ITA_B_SBYTE_NORST];
   endproperty
   a_sbyte_reassert: assert property (p_sbyte_reassert)
      else $error("start byte abort did not re-assert");

   property p_sbyte_fixed;
      sbyte_fixed |=> !sbyte_cond_r;
   endproperty
   a_sbyte_fixed: assert property (p_sbyte_fixed)
      else $error("start byte condition survived fix");

   property p_hs_norst;
      req_high_speed && !restart_en |=> cause_r[ITA_B_HS_NORST];
   endproperty
   a_hs_norst: assert property (p_hs_norst)
      else $error("high speed abort not set");

   property p_sbyte_acked;
      ack_valid && ack_seen && kind_r == ITA_KIND_SBYTE
      && !cause_r[ITA_B_SBYTE_ACKED]
      |=> cause_r[ITA_B_SBYTE_ACKED] && master_abort;
   endproperty
   a_sbyte_acked: assert property (p_sbyte_acked)
      else $error("acked start byte not flagged");

   property p_gcall_noack;
      ack_valid && !ack_seen && kind_r == ITA_KIND_GCALL
      |=> cause_r[ITA_B_GCALL_NOACK] && !$past(set_vec[ITA_B_GCALL_READ]);
   endproperty
   a_gcall_noack: assert property (p_gcall_noack)
      else $error("general call no-ack not flagged");

   property p_data_noack;
      ack_valid && !ack_seen && kind_r == ITA_KIND_DATA && mst_mode
      |=> cause_r[ITA_B_DATA_NOACK];
   endproperty
   a_data_noack: assert property (p_data_noack)
      else $error("data no-ack not flagged");

   property p_seven_noack;
      ack_valid && !ack_seen && kind_r == ITA_KIND_ADDR7
      |=> cause_r[ITA_B_SEVEN_NOACK];
   endproperty
   a_seven_noack: assert property (p_seven_noack)
      else $error("address no-ack not flagged");

   property p_hs_acked;
      ack_valid && ack_seen && kind_r == ITA_KIND_HSCODE
      |=> cause_r[ITA_B_HS_ACKED];
   endproperty
   a_hs_acked: assert property (p_hs_acked)
      else $error("acked high speed code not flagged");

   property p_gcall_read;
      ack_valid && ack_seen && kind_r == ITA_KIND_GCALL && next_cmd_read
      |=> cause_r[ITA_B_GCALL_READ];
   endproperty
   a_gcall_read: assert property (p_gcall_read)
      else $error("general call read not flagged");

   property p_ten2_noack;
      ack_valid && !ack_seen && kind_r == ITA_KIND_ADDR10_2
      |=> cause_r[ITA_B_TEN2_NOACK];
   endproperty
   a_ten2_noack: assert property (p_ten2_noack)
      else $error("second address byte no-ack not flagged");

   property p_ten1_noack;
      ack_valid && !ack_seen && kind_r == ITA_KIND_ADDR10_1
      |=> cause_r[ITA_B_TEN1_NOACK];
   endproperty
   a_ten1_noack: assert property (p_ten1_noack)
      else $error("first address byte no-ack not flagged");

   property p_abort_irq;
      master_abort && int_mask_r |=> int_stat_r ##0 irq;
   endproperty
   a_abort_irq: assert property (p_abort_irq)
      else $error("abort did not raise interrupt");

   property p_cause_readonly;
      wr_en && paddr == ITA_ADDR_CAUSE && set_vec == '0
      |=> cause_r == $past(cause_r);
   endproperty
   a_cause_readonly: assert property (p_cause_readonly)
      else $error("cause register changed by write");

   c_sbyte_cycle: cover property (
      clr_vec[ITA_B_SBYTE_NORST] && sbyte_cond_r
      ##1 !cause_r[ITA_B_SBYTE_NORST] ##1 cause_r[ITA_B_SBYTE_NORST]);
   c_seven_noack: cover property (cause_r[ITA_B_SEVEN_NOACK]);
   c_gcall_read: cover property (cause_r[ITA_B_GCALL_READ]);
   c_irq: cover property (irq);
endmodule : ita_abort_cause

// ==== tb/ita_slave_model.sv ====
`timescale 1ns/100ps
module ita_slave_model (
   output logic scl,
   output logic sda
);
   // Bus idles high through the pull-ups
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end

   // Eight data bits, then ACK low or released high on the ninth rise
   task automatic send_byte(input logic ack);
      int i;
      #137;
      for (i = 1; i <= 9; i++) begin
         scl = 1'b0;
         #200;
         sda = (i == 9) ? ~ack : i[0];
         #200;
         scl = 1'b1;
         #400;
      end
      scl = 1'b0;
      #200;
      sda = 1'b1;
      #200;
      scl = 1'b1;
   endtask : send_byte
endmodule : ita_slave_model

// ==== tb/i2c_tx_abort_source_low_test.sv ====
`timescale 1ns/100ps
module i2c_tx_abort_source_low_test;
   import ita_pkg::*;
   typedef struct packed {
      ita_kind_t   kind;
      logic        ack;
      logic        mst;
      logic        rd;
      logic [15:0] exp;
   } ita_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic scl_in, sda_in, mst_mode, byte_start, next_cmd_read;
   logic req_start_byte, req_high_speed, master_abort, irq, err, got;
   ita_kind_t byte_kind;
   int n_mismatch, checks_done, n_abort, na, i;
   ita_row_t rows [11] = '{
      '{ITA_KIND_ADDR7,    1'b0, 1'b1, 1'b0, 16'h0001},
      '{ITA_KIND_ADDR10_1, 1'b0, 1'b1, 1'b0, 16'h0002},
      '{ITA_KIND_ADDR10_2, 1'b0, 1'b1, 1'b0, 16'h0004},
      '{ITA_KIND_DATA,     1'b0, 1'b1, 1'b0, 16'h0008},
      '{ITA_KIND_GCALL,    1'b0, 1'b1, 1'b0, 16'h0010},
      '{ITA_KIND_GCALL,    1'b1, 1'b1, 1'b1, 16'h0020},
      '{ITA_KIND_HSCODE,   1'b1, 1'b1, 1'b0, 16'h0040},
      '{ITA_KIND_SBYTE,    1'b1, 1'b1, 1'b0, 16'h0080},
      '{ITA_KIND_ADDR7,    1'b1, 1'b1, 1'b0, 16'h0000},
      '{ITA_KIND_GCALL,    1'b1, 1'b1, 1'b0, 16'h0000},
      '{ITA_KIND_DATA,     1'b0, 1'b0, 1'b0, 16'h0000}};

   ita_abort_cause ita_abort_cause_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in),
      .mst_mode(mst_mode), .byte_start(byte_start),
      .byte_kind(byte_kind), .next_cmd_read(next_cmd_read),
      .req_start_byte(req_start_byte), .req_high_speed(req_high_speed),
      .master_abort(master_abort), .irq(irq));
   ita_slave_model ita_slave_model_inst (.scl(scl_in), .sda(sda_in));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) if (master_abort === 1'b1) n_abort <= n_abort + 1;

   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One APB transfer, started right after a rising edge
   task automatic apb(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_mismatch++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle cycle so a following call never reassigns psel this step
      @(posedge pclk);
   endtask : apb

   task automatic rdchk(input string nm, input logic [31:0] a,
                        input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask : rdchk

   // Bounded wait for a new abort pulse
   task automatic wait_abort;
      int n;
      for (n = 0; n < 40 && n_abort == na; n++) @(posedge pclk);
      got = (n_abort != na);
   endtask : wait_abort

   task automatic pulse_req(input logic sb);
      na = n_abort;
      req_start_byte <= sb;
      req_high_speed <= ~sb;
      @(posedge pclk);
      req_start_byte <= 1'b0;
      req_high_speed <= 1'b0;
   endtask : pulse_req

   task automatic clr_all;
      apb(1'b1, ITA_ADDR_CLEAR, 32'h0000_03FF);
      apb(1'b1, ITA_ADDR_INT_STAT, 32'h0000_0001);
   endtask : clr_all

   task automatic run_byte(input ita_row_t r);
      // Abort pulse comes while the byte is still on the bus
      na = n_abort;
      mst_mode <= r.mst;
      next_cmd_read <= r.rd;
      byte_kind <= r.kind;
      byte_start <= 1'b1;
      @(posedge pclk);
      byte_start <= 1'b0;
      ita_slave_model_inst.send_byte(r.ack);
      wait_abort();
   endtask : run_byte

   initial begin
      {presetn, psel, penable, pwrite, mst_mode, byte_start} = '0;
      {next_cmd_read, req_start_byte, req_high_speed} = '0;
      {paddr, pwdata, n_mismatch, checks_done} = '0;
      byte_kind = ITA_KIND_NONE;
      repeat (8) @(posedge pclk);
      chk("abort_in_reset", 32'h0, {31'h0, master_abort});
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk("cause_reset", ITA_ADDR_CAUSE, 32'h0);
      apb(1'b1, ITA_ADDR_CAUSE, 32'h0000_FFFF);
      rdchk("cause_ro", ITA_ADDR_CAUSE, 32'h0);
      apb(1'b0, 32'h5000_13F0, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, err});
      apb(1'b1, ITA_ADDR_INT_MASK, 32'h0000_0001);
      for (i = 0; i < 11; i++) begin
         run_byte(rows[i]);
         chk("abort", {31'h0, rows[i].exp != 0}, {31'h0, got});
         rdchk("cause", ITA_ADDR_CAUSE, rows[i].exp);
         chk("irq", {31'h0, rows[i].exp != 0}, {31'h0, irq});
         clr_all();
         chk("irq_clr", 32'h0, {31'h0, irq});
      end
      apb(1'b1, ITA_ADDR_INT_MASK, 32'h0);
      run_byte(rows[0]);
      chk("irq_masked", 32'h0, {31'h0, irq});
      rdchk("cause_masked", ITA_ADDR_CAUSE, 32'h1);
      clr_all();
      apb(1'b1, ITA_ADDR_CTRL, 32'h0);
      pulse_req(1'b0);
      wait_abort();
      rdchk("hs_norst", ITA_ADDR_CAUSE, 32'h100);
      clr_all();
      apb(1'b1, ITA_ADDR_CTRL, 32'h20);
      pulse_req(1'b0);
      wait_abort();
      rdchk("hs_rst_on", ITA_ADDR_CAUSE, 32'h0);
      for (i = 0; i < 3; i++) begin
         apb(1'b1, ITA_ADDR_CTRL, 32'h0);
         apb(1'b1, ITA_ADDR_TARGET, 32'h0C00);
         pulse_req(1'b1);
         wait_abort();
         rdchk("sb_norst", ITA_ADDR_CAUSE, 32'h200);
         na = n_abort;
         apb(1'b1, ITA_ADDR_CLEAR, 32'h200);
         repeat (8) @(posedge pclk);
         chk("sb_reassert", na + 1, n_abort);
         rdchk("sb_held", ITA_ADDR_CAUSE, 32'h200);
         // Each of the three ways to remove the condition
         if (i == 0) apb(1'b1, ITA_ADDR_CTRL, 32'h20);
         else apb(1'b1, ITA_ADDR_TARGET, (i == 1) ? 32'h400 : 32'h800);
         apb(1'b1, ITA_ADDR_CLEAR, 32'h200);
         repeat (4) @(posedge pclk);
         rdchk("sb_fixed", ITA_ADDR_CAUSE, 32'h0);
      end
      print_verdict();
   end
endmodule : i2c_tx_abort_source_low_test
